// ==== rtl/ehc_ctrl.sv ====
// controller end: bus registers driving the sensor pins and register port
`timescale 1ns/100ps
`include "ehc_params.svh"
module ehc_ctrl (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    ehc_link_if.ctrl link
);

    ehc_pkg::ehc_host_t q;
    ehc_pkg::ehc_host_t next_q;
    logic take;
    logic [2:0] fire;
    logic [31:0] rmux;

    always_comb begin
        next_q = q;
        // only whole-word singles are issued, so hsize is not decoded
        take = hsel_i & htrans_i[1] & hready_i;
        next_q.dp_wr = take & hwrite_i;
        next_q.dp_addr = haddr_i[3:2];
        case (haddr_i[3:2])
            `EHC_HOFS_DEVCMD: rmux = {15'h0, q.busy, q.l_wdata, 1'h0, q.l_addr};
            `EHC_HOFS_DEVRD: rmux = {23'h0, q.busy, q.rd};
            `EHC_HOFS_PIN: rmux = {q.gap, 12'h0, q.armed, q.pin};
            default: rmux = {16'h0, q.fcnt, 6'h0, link.inte_odd, link.inte_even};
        endcase
        if (take & ~hwrite_i) begin
            next_q.hrdata = rmux;
        end

        next_q.l_wr = 1'b0;
        next_q.l_rd = 1'b0;
        fire = 3'h0;
        if (link.reg_rvalid) begin
            next_q.rd = link.reg_rdata;
            next_q.busy = 1'b0;
        end
        if (link.frame_done) begin
            next_q.fcnt = q.fcnt + 8'h1;
        end

        if (q.dp_wr) begin
            case (q.dp_addr)
                `EHC_HOFS_DEVCMD: begin
                    // a new access is ignored while a read is outstanding
                    if (!q.busy) begin
                        next_q.l_addr = hwdata_i[6:0];
                        next_q.l_wdata = hwdata_i[15:8];
                        next_q.l_wr = hwdata_i[16];
                        next_q.l_rd = ~hwdata_i[16];
                        next_q.busy = ~hwdata_i[16];
                    end
                end
                `EHC_HOFS_PIN: begin
                    fire[0] = hwdata_i[0];
                    fire[1] = hwdata_i[1];
                    next_q.armed = hwdata_i[2];
                    next_q.gap = hwdata_i[31:16];
                end
                default: ;
            endcase
        end

        // request edge follows the start edge by the gap, one clock at least
        if (q.armed) begin
            if (q.gap <= 16'h1) begin
                fire[2] = 1'b1;
                next_q.armed = 1'b0;
            end else begin
                next_q.gap = q.gap - 16'h1;
            end
        end

        // a pin still high gives no new edge when fired again
        for (int i = 0; i < 3; i++) begin
            if (fire[i]) begin
                next_q.pin[i] = 1'b1;
                next_q.cnt[i] = `EHC_PIN_HIGH;
            end else if (q.cnt[i] != 4'h0) begin
                next_q.cnt[i] = q.cnt[i] - 4'h1;
            end else begin
                next_q.pin[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= next_q;
        end
    end

    assign hrdata_o = q.hrdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign link.exp_start_a = q.pin[0];
    assign link.exp_start_b = q.pin[1];
    assign link.frame_req = q.pin[2];
    assign link.reg_wr = q.l_wr;
    assign link.reg_rd = q.l_rd;
    assign link.reg_addr = q.l_addr;
    assign link.reg_wdata = q.l_wdata;

endmodule

// ==== rtl/ehc_device.sv ====
// sensor end: exposure timing, interleaved exposure and colour row grouping
// Summary of operation
// - mode bit selects register or pin timing
// - internal: 129 clocks times (0.43*fot + exp)
// - fot term comes from its own register
// - external: start pin edge to request edge
// - external adds 129*0.43*fot clocks overhead
// - one-clock start-to-request gap is accepted
// - controller programs exposure register to one minimum
// - short exposures: fot five, fastest clock
// - dual bit enables separate even/odd exposure
// - dual internal: even rows use primary register
// - dual internal: odd rows use second register
// - dual external: pin a even, pin b odd
// - every hdr option works in both modes
// - mono resets one; colour groups Bayer row pairs
`timescale 1ns/100ps
`include "ehc_params.svh"
module ehc_device (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    ehc_link_if.sensor link,
    input wire logic [10:0] row_index_i,
    output logic row_is_odd_o,
    output logic readout_start_o
);

    ehc_pkg::ehc_dev_t q;
    ehc_pkg::ehc_dev_t next_q;
    logic rise_a;
    logic rise_b;
    logic rise_fr;
    logic [39:0] acc_inc;
    logic [39:0] fot_hund;
    logic [7:0] rd;

    // exposure target in hundredths of a clock, so 0.43 stays exact
    function automatic logic [39:0] ehc_target(input logic [7:0] fot, input logic [23:0] exp);
        logic [39:0] fot_part;
        logic [39:0] exp_part;
        fot_part = {32'h0, fot} * `EHC_FOT_HUND;
        exp_part = {16'h0, exp} * `EHC_EXP_HUND;
        ehc_target = fot_part + exp_part;
    endfunction

    always_comb begin
        next_q = q;
        // two flops per pin, then edge against the delayed copy
        next_q.sa_m = link.exp_start_a;
        next_q.sa_s = q.sa_m;
        next_q.sa_d = q.sa_s;
        next_q.sb_m = link.exp_start_b;
        next_q.sb_s = q.sb_m;
        next_q.sb_d = q.sb_s;
        next_q.fr_m = link.frame_req;
        next_q.fr_s = q.fr_m;
        next_q.fr_d = q.fr_s;

        // delayed copies reset low like the idle pins, so reset gives no false edge
        rise_a = q.sa_s & ~q.sa_d;
        rise_b = q.sb_s & ~q.sb_d;
        rise_fr = q.fr_s & ~q.fr_d;
        acc_inc = q.acc + `EHC_STEP;
        fot_hund = ehc_target(q.fot, 24'h0);
        next_q.done = 1'b0;
        next_q.rvalid = 1'b0;

        // register writes; exposure values are used from the next exposure start, external fot from the request edge
        if (link.reg_wr) begin
            case (link.reg_addr)
                `EHC_ADDR_COLOR: next_q.mono = link.reg_wdata[0];
                `EHC_ADDR_MODE: begin
                    next_q.ext = link.reg_wdata[`EHC_BIT_EXT];
                    next_q.dual = link.reg_wdata[`EHC_BIT_DUAL];
                end
                `EHC_ADDR_EXP1: next_q.exp1[7:0] = link.reg_wdata;
                `EHC_ADDR_EXP1 + 7'h1: next_q.exp1[15:8] = link.reg_wdata;
                `EHC_ADDR_EXP1 + 7'h2: next_q.exp1[23:16] = link.reg_wdata;
                `EHC_ADDR_EXP2: next_q.exp2[7:0] = link.reg_wdata;
                `EHC_ADDR_EXP2 + 7'h1: next_q.exp2[15:8] = link.reg_wdata;
                `EHC_ADDR_EXP2 + 7'h2: next_q.exp2[23:16] = link.reg_wdata;
                `EHC_ADDR_FOT: next_q.fot = link.reg_wdata;
                default: ;
            endcase
        end

        // register reads answer one clock later; unmapped reads give zero
        case (link.reg_addr)
            `EHC_ADDR_COLOR: rd = {7'h0, q.mono};
            `EHC_ADDR_MODE: rd = {6'h0, q.dual, q.ext};
            `EHC_ADDR_EXP1: rd = q.exp1[7:0];
            `EHC_ADDR_EXP1 + 7'h1: rd = q.exp1[15:8];
            `EHC_ADDR_EXP1 + 7'h2: rd = q.exp1[23:16];
            `EHC_ADDR_EXP2: rd = q.exp2[7:0];
            `EHC_ADDR_EXP2 + 7'h1: rd = q.exp2[15:8];
            `EHC_ADDR_EXP2 + 7'h2: rd = q.exp2[23:16];
            `EHC_ADDR_FOT: rd = q.fot;
            `EHC_ADDR_STAT: rd = {5'h0, q.st != ehc_pkg::EHC_IDLE, q.inte_o, q.inte_e};
            default: rd = 8'h00;
        endcase

        if (link.reg_rd) begin
            next_q.rdata = rd;
            next_q.rvalid = 1'b1;
        end

        case (q.st)
            ehc_pkg::EHC_IDLE: begin
                // mode frozen per frame so a late write cannot split an exposure
                next_q.run_ext = q.ext;
                next_q.run_dual = q.dual;
                if (q.ext) begin
                    // external: exposure opens on a start pin edge
                    if (rise_a) begin
                        next_q.inte_e = 1'b1;
                        next_q.inte_o = ~q.dual;
                        next_q.st = ehc_pkg::EHC_EXPOSE;
                    end
                    if (rise_b && q.dual) begin
                        next_q.inte_o = 1'b1;
                        next_q.st = ehc_pkg::EHC_EXPOSE;
                    end
                end else if (rise_fr) begin
                    // internal: request starts both row groups at once
                    next_q.tgt_e = ehc_target(q.fot, q.exp1);
                    next_q.tgt_o = ehc_target(q.fot, q.dual ? q.exp2 : q.exp1);
                    next_q.acc = 40'h0;
                    next_q.inte_e = 1'b1;
                    next_q.inte_o = 1'b1;
                    next_q.st = ehc_pkg::EHC_EXPOSE;
                end
            end
            ehc_pkg::EHC_EXPOSE: begin
                if (q.run_ext) begin
                    if (rise_a) begin
                        next_q.inte_e = 1'b1;
                        next_q.inte_o = q.inte_o | ~q.run_dual;
                    end
                    if (rise_b && q.run_dual) begin
                        next_q.inte_o = 1'b1;
                    end
                    // request edge may follow the start edge by one clock
                    if (rise_fr) begin
                        next_q.acc = 40'h0;
                        next_q.tgt_e = fot_hund;
                        next_q.st = ehc_pkg::EHC_OVER;
                    end
                end else begin
                    // each group closes on its own target; done waits for both
                    next_q.acc = acc_inc;
                    if (acc_inc >= q.tgt_e) begin
                        next_q.inte_e = 1'b0;
                    end
                    if (acc_inc >= q.tgt_o) begin
                        next_q.inte_o = 1'b0;
                    end
                    if (acc_inc >= q.tgt_e && acc_inc >= q.tgt_o) begin
                        next_q.done = 1'b1;
                        next_q.st = ehc_pkg::EHC_IDLE;
                    end
                end
            end
            ehc_pkg::EHC_OVER: begin
                // fixed overhead after the pin-defined interval
                next_q.acc = acc_inc;
                if (acc_inc >= q.tgt_e) begin
                    next_q.inte_e = 1'b0;
                    next_q.inte_o = 1'b0;
                    next_q.done = 1'b1;
                    next_q.st = ehc_pkg::EHC_IDLE;
                end
            end
            default: next_q.st = ehc_pkg::EHC_IDLE;
        endcase

        // colour parts pair rows so each group keeps a full Bayer cell
        if (q.mono) begin
            next_q.row_odd = row_index_i[0];
        end else begin
            next_q.row_odd = row_index_i[1];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '0;
            q.st <= ehc_pkg::EHC_IDLE;
            q.mono <= `EHC_RST_MONO;
            q.exp1 <= `EHC_RST_EXP;
            q.exp2 <= `EHC_RST_EXP;
            q.fot <= `EHC_RST_FOT;
        end else if (ce_i) begin
            q <= next_q;
        end
    end

    assign link.reg_rdata = q.rdata;
    assign link.reg_rvalid = q.rvalid;
    assign link.inte_even = q.inte_e;
    assign link.inte_odd = q.inte_o;
    assign link.frame_done = q.done;
    assign row_is_odd_o = q.row_odd;
    assign readout_start_o = q.done;

endmodule

// ==== rtl/ehc_link_if.sv ====
// link between the camera controller and the sensor exposure logic
`timescale 1ns/100ps
interface ehc_link_if;
    logic exp_start_a;
    logic exp_start_b;
    logic frame_req;
    logic reg_wr;
    logic reg_rd;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic inte_even;
    logic inte_odd;
    logic frame_done;

    modport sensor (
        input exp_start_a, exp_start_b, frame_req, reg_wr, reg_rd, reg_addr, reg_wdata,
        output reg_rdata, reg_rvalid, inte_even, inte_odd, frame_done
    );
    modport ctrl (
        output exp_start_a, exp_start_b, frame_req, reg_wr, reg_rd, reg_addr, reg_wdata,
        input reg_rdata, reg_rvalid, inte_even, inte_odd, frame_done
    );
endinterface

// ==== rtl/ehc_params.svh ====
// constants of the exposure control block: offsets, reset values, timing
`ifndef EHC_PARAMS_SVH
`define EHC_PARAMS_SVH

// sensor register offsets (byte registers, 7-bit index)
`define EHC_ADDR_COLOR 7'h27
`define EHC_ADDR_MODE 7'h29
`define EHC_ADDR_EXP1 7'h2a
`define EHC_ADDR_EXP2 7'h38
`define EHC_ADDR_FOT 7'h49
`define EHC_ADDR_STAT 7'h7f

// mode register field positions
`define EHC_BIT_EXT 0
`define EHC_BIT_DUAL 1

// sensor reset values
`define EHC_RST_MONO 1'h1
`define EHC_RST_EXP 24'h000440
`define EHC_RST_FOT 8'h0a

// timing: exposure counted in hundredths of a clock
`define EHC_ROW_CLKS 40'd129
`define EHC_FOT_PCT 40'd43
`define EHC_STEP 40'd100
`define EHC_FOT_HUND (`EHC_ROW_CLKS * `EHC_FOT_PCT)
`define EHC_EXP_HUND (`EHC_ROW_CLKS * `EHC_STEP)

// controller bus offsets
`define EHC_HOFS_DEVCMD 2'h0
`define EHC_HOFS_DEVRD 2'h1
`define EHC_HOFS_PIN 2'h2
`define EHC_HOFS_STAT 2'h3

// controller pin pulse length in extra clocks
`define EHC_PIN_HIGH 4'h4

`endif

// ==== rtl/ehc_pkg.sv ====
// types shared by both ends of the exposure control link
package ehc_pkg;

    typedef enum {EHC_IDLE, EHC_EXPOSE, EHC_OVER} ehc_state_t;

    typedef struct packed {
        logic sa_m;
        logic sa_s;
        logic sa_d;
        logic sb_m;
        logic sb_s;
        logic sb_d;
        logic fr_m;
        logic fr_s;
        logic fr_d;
        logic ext;
        logic dual;
        logic mono;
        logic run_ext;
        logic run_dual;
        logic [23:0] exp1;
        logic [23:0] exp2;
        logic [7:0] fot;
        ehc_state_t st;
        logic [39:0] acc;
        logic [39:0] tgt_e;
        logic [39:0] tgt_o;
        logic inte_e;
        logic inte_o;
        logic done;
        logic [7:0] rdata;
        logic rvalid;
        logic row_odd;
    } ehc_dev_t;

    typedef struct packed {
        logic dp_wr;
        logic [1:0] dp_addr;
        logic [31:0] hrdata;
        logic l_wr;
        logic l_rd;
        logic [6:0] l_addr;
        logic [7:0] l_wdata;
        logic busy;
        logic [7:0] rd;
        logic [2:0] pin;
        logic [2:0][3:0] cnt;
        logic armed;
        logic [15:0] gap;
        logic [7:0] fcnt;
    } ehc_host_t;

endpackage

// ==== verif/ehc_link_monitor.sv ====
// concurrent checks on the exposure link signals
`timescale 1ns/100ps
module ehc_link_monitor (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic exp_start_a,
    input wire logic exp_start_b,
    input wire logic frame_req,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_rvalid,
    input wire logic inte_even,
    input wire logic inte_odd,
    input wire logic frame_done
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    sequence rd_req_s;
        reg_rd;
    endsequence
    sequence rd_ans_s;
        ##1 reg_rvalid;
    endsequence
    read_answer_a: assert property (rd_req_s |-> rd_ans_s)
        else $error("read strobe not answered");
    answer_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read answer without strobe");
    strobe_excl_a: assert property (!(reg_wr && reg_rd))
        else $error("read and write strobes together");
    done_idle_a: assert property (frame_done |-> !inte_even && !inte_odd)
        else $error("frame done while exposing");
    done_pulse_a: assert property (frame_done |=> !frame_done)
        else $error("frame done longer than one cycle");
    // window of two, though in both modes done rises on the clock the last flag drops
    done_after_a: assert property (frame_done |-> $past(inte_even || inte_odd) || $past(inte_even || inte_odd, 2))
        else $error("frame done without exposure");
    // pin flop to exposure flag is two sync stages plus the edge stage
    even_cause_a: assert property ($rose(inte_even) |-> $past(exp_start_a, 3) || $past(frame_req, 3))
        else $error("even exposure without pin edge");
    odd_cause_a: assert property ($rose(inte_odd) |->
        $past(exp_start_a, 3) || $past(exp_start_b, 3) || $past(frame_req, 3))
        else $error("odd exposure without pin edge");
    pin_width_a: assert property ($rose(exp_start_a) |-> exp_start_a [*5] ##1 !exp_start_a)
        else $error("start pin pulse width");
endmodule

// ==== verif/exposure_hdr_interleave_control_test.sv ====
// self-checking bench joining controller and sensor ends
`timescale 1ns/100ps
module exposure_hdr_interleave_control_test;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [10:0] row = 11'h0;
    logic row_odd;
    logic rd_start;
    int miscompares = 0;
    int tests_run = 0;
    logic [6:0] ra [10] = '{7'h27, 7'h29, 7'h2a, 7'h2b, 7'h2c, 7'h38, 7'h39, 7'h3a, 7'h10, 7'h7f};
    logic [7:0] rv [10] = '{8'h01, 8'h00, 8'h40, 8'h04, 8'h00, 8'h40, 8'h04, 8'h00, 8'h00, 8'h00};
    ehc_link_if u_ehc_link_if ();
    ehc_ctrl u_ehc_ctrl (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .link(u_ehc_link_if));
    ehc_device u_ehc_device (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .link(u_ehc_link_if),
        .row_index_i(row), .row_is_odd_o(row_odd), .readout_start_o(rd_start));
    ehc_link_monitor u_ehc_link_monitor (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .exp_start_a(u_ehc_link_if.exp_start_a), .exp_start_b(u_ehc_link_if.exp_start_b),
        .frame_req(u_ehc_link_if.frame_req), .reg_wr(u_ehc_link_if.reg_wr), .reg_rd(u_ehc_link_if.reg_rd),
        .reg_rvalid(u_ehc_link_if.reg_rvalid), .inte_even(u_ehc_link_if.inte_even),
        .inte_odd(u_ehc_link_if.inte_odd), .frame_done(u_ehc_link_if.frame_done));
    initial begin
        forever #50 mclk_i = ~mclk_i;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk_i);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge mclk_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge mclk_i); while (hready !== 1'b1);
        q = hrdata;
        check("bus response", hresp, 32'h0);
    endtask
    task automatic dev(input logic wr, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [31:0] r;
        int n;
        n = 0;
        bus(1'b1, 32'h0, {15'h0, wr, d, 1'b0, a}, r);
        do begin
            bus(1'b0, 32'h4, 32'h0, r);
            n++;
        end while (r[8] !== 1'b0 && n < 20);
        q = r[7:0];
    endtask
    // lengths in clocks, 129 and 0.43 kept in hundredths and rounded up
    function automatic int xlen(input int fot, input int e);
        return (fot * 5547 + e * 12900 + 99) / 100;
    endfunction
    task automatic expose(input logic b_first, input logic [31:0] pin, output int ne, output int no);
        logic [31:0] r;
        int k;
        ne = 0;
        no = 0;
        if (b_first) begin
            bus(1'b1, 32'h8, 32'h2, r);
        end
        bus(1'b1, 32'h8, pin, r);
        for (k = 0; k < 3000; k++) begin
            // sample away from the edge that launches the flags
            @(negedge mclk_i);
            ne += u_ehc_link_if.inte_even;
            no += u_ehc_link_if.inte_odd;
            if (u_ehc_link_if.frame_done === 1'b1) break;
        end
        check("readout start", rd_start, 32'h1);
    endtask
    task automatic t_reset();
        logic [7:0] q;
        int i;
        for (i = 0; i < 10; i++) begin
            dev(1'b0, ra[i], 8'h0, q);
            check("reset register", q, rv[i]);
        end
        $display("test reset done");
    endtask
    task automatic t_internal();
        logic [7:0] q;
        int ne, no;
        dev(1'b1, 7'h49, 8'h05, q);
        dev(1'b1, 7'h2a, 8'h01, q);
        dev(1'b1, 7'h2b, 8'h00, q);
        dev(1'b1, 7'h38, 8'h03, q);
        dev(1'b1, 7'h39, 8'h00, q);
        expose(1'b0, 32'h00010005, ne, no);
        check("internal even", ne, xlen(5, 1));
        check("internal odd", no, xlen(5, 1));
        dev(1'b1, 7'h29, 8'h02, q);
        expose(1'b0, 32'h00010005, ne, no);
        check("dual even", ne, xlen(5, 1));
        check("dual odd", no, xlen(5, 3));
        $display("test internal done");
    endtask
    task automatic t_external();
        logic [7:0] q;
        logic [31:0] r;
        int ne, no;
        dev(1'b1, 7'h29, 8'h01, q);
        expose(1'b0, 32'h00010005, ne, no);
        check("one cycle gap even", ne, 1 + xlen(5, 0));
        check("one cycle gap odd", no, 1 + xlen(5, 0));
        expose(1'b0, 32'h00140005, ne, no);
        check("long gap", ne, 20 + xlen(5, 0));
        dev(1'b1, 7'h29, 8'h03, q);
        expose(1'b1, 32'h001e0005, ne, no);
        check("dual ext even", ne, 30 + xlen(5, 0));
        check("dual ext odd longer", no > ne, 1);
        bus(1'b0, 32'hc, 32'h0, r);
        check("frames done", r[15:8], 8'h05);
        $display("test external done");
    endtask
    task automatic t_colour();
        logic [7:0] q;
        int m, i;
        for (m = 1; m >= 0; m--) begin
            dev(1'b1, 7'h27, m[7:0], q);
            for (i = 0; i < 4; i++) begin
                row <= i[10:0];
                @(posedge mclk_i);
                @(posedge mclk_i);
                check("row group", row_odd, m[0] ? i[0] : i[1]);
            end
        end
        $display("test colour done");
    endtask
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_internal();
        t_external();
        t_colour();
        end_sim();
    end
    // frames here are under a thousand clocks each
    initial begin
        repeat (40000) @(posedge mclk_i);
        miscompares++;
        end_sim();
    end
endmodule
